// >>> sis_pkg.sv
// constants and carriers for the shutter interlock supervisor
// assumes a 40 MHz core clock and a synchronous active-high reset
// Functional notes
// - beam modulation passes only while the safety loop is closed
// - closed shutter loop means shutter fitted; shutter works only then
// - shutter driven open or closed following the request level
// - closed indication only when fitted and sensed closed, never during latched faults
// - open indication while fitted shutter is sensed open and no fault is latched
// - latch shutter fault on reported fault or stuck between positions
// - latch over-temperature fault; it shuts the whole system down
// - request high means open, low means closed
// - fault on travel timeout or close requested without closed indication
// - safety loop overrides modulation only; shutter loop disables only the shutter
`default_nettype none
package sis_pkg;
  // travel time allowed, in microseconds
  localparam int unsigned TRAVEL_TIME_US  = 500;
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned TRAVEL_CYC      = TRAVEL_TIME_US * CLK_MHZ;
  localparam int unsigned TMR_W           = 20;
  localparam logic [1:0]  SYNC_RST        = 2'h0;

  typedef enum logic [1:0] {
    SIS_IDLE   = 2'b00,
    SIS_MOVING = 2'b01,
    SIS_FAULT  = 2'b10
  } sis_state_e;

  // synchronised field pins
  typedef struct packed {
    logic safety_loop;
    logic shutter_loop;
    logic open_req;
    logic sense_open;
    logic sense_closed;
    logic shutter_err;
    logic over_temp;
  } sis_pins_s;
endpackage
`default_nettype wire

// >>> sis_supervisor.sv
// shutter interlock supervisor: gating, shutter drive, latched faults
// assumes every field input is asynchronous to core_clk_in
// assumes mod_req_in and fault_clr_in come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module sis_supervisor #(
  parameter int unsigned TRAVEL_CYC = sis_pkg::TRAVEL_CYC
) (
  input  wire logic               core_clk_in,
  input  wire logic               srst_in,
  input  wire sis_pkg::sis_pins_s pins_in,
  input  wire logic               mod_req_in,
  input  wire logic               fault_clr_in,
  output logic                    mod_en_out,
  output logic                    shutter_drive_out,
  output logic                    shutter_closed_out,
  output logic                    shutter_open_out,
  output logic                    shutter_fault_out,
  output logic                    over_temp_fault_out,
  output logic                    shutdown_out
);
  localparam int W     = $bits(sis_pkg::sis_pins_s);
  localparam int TMR_W = sis_pkg::TMR_W;

  // three-stage synchronisers; a change counts when stages two and three agree
  logic [W-1:0] s1_r, s2_r, s3_r, flt_r;
  logic [W-1:0] agree;
  always_ff @(posedge core_clk_in) begin
    s1_r <= pins_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  // per-pin agreement of the last two stages
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_flt
      assign agree[g] = (s2_r[g] == s3_r[g]);
    end
  endgenerate
  // filtered copy takes a pin only while its two stages agree
  always_ff @(posedge core_clk_in) begin
    if (srst_in) flt_r <= '0;
    else         flt_r <= (flt_r & ~agree) | (s3_r & agree);
  end
  sis_pkg::sis_pins_s p;
  assign p = flt_r;

  sis_pkg::sis_state_e state_r, state_nxt;
  logic [sis_pkg::TMR_W-1:0] tmr_r;
  logic req_r, sh_flt_r, ot_flt_r, mod_r, clo_r, opn_r;

  // decode; shutter loop only gates the shutter, safety loop gates only modulation
  wire fitted      = p.shutter_loop;
  wire any_fault   = sh_flt_r | ot_flt_r;
  wire shut_en     = fitted & ~any_fault;
  wire cmd_open    = p.open_req;
  wire req_change  = shut_en & (cmd_open != req_r);
  wire at_target   = cmd_open ? p.sense_open : p.sense_closed;
  wire tmr_done    = (tmr_r == '0);
  wire travel_bad  = (state_r == sis_pkg::SIS_MOVING) & tmr_done & ~at_target;
  wire settled     = (state_r == sis_pkg::SIS_IDLE) & ~req_change;  // not in the change cycle
  wire close_bad   = settled & ~cmd_open & ~p.sense_closed;
  wire stuck_bad   = settled & ~p.sense_open & ~p.sense_closed;
  wire move_bad    = travel_bad | close_bad | stuck_bad;
  wire sh_flt_set  = (fitted & p.shutter_err) | (shut_en & move_bad);

  // travel sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sis_pkg::SIS_IDLE:   if (req_change) state_nxt = sis_pkg::SIS_MOVING;
      sis_pkg::SIS_MOVING: if (at_target & ~req_change) state_nxt = sis_pkg::SIS_IDLE;
      sis_pkg::SIS_FAULT:  if (~any_fault) state_nxt = sis_pkg::SIS_IDLE;
      default:             state_nxt = sis_pkg::SIS_IDLE;
    endcase
    if (any_fault | sh_flt_set | ~fitted) state_nxt = any_fault ? sis_pkg::SIS_FAULT
                                                                 : sis_pkg::SIS_IDLE;
  end

  // timer reload on each commanded change
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_r <= sis_pkg::SIS_IDLE;
      tmr_r   <= '0;
      req_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r   <= shut_en ? cmd_open : 1'b0;
      if (req_change) tmr_r <= TMR_W'(TRAVEL_CYC);
      else if (!tmr_done) tmr_r <= tmr_r - 1'b1;
    end
  end

  // latched faults; a new event wins over clear
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sh_flt_r <= 1'b0;
      ot_flt_r <= 1'b0;
    end else begin
      sh_flt_r <= sh_flt_set | (sh_flt_r & ~fault_clr_in);
      ot_flt_r <= p.over_temp | (ot_flt_r & ~fault_clr_in);
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mod_r <= 1'b0;
      clo_r <= 1'b0;
      opn_r <= 1'b0;
    end else begin
      mod_r <= mod_req_in & p.safety_loop & ~any_fault;
      clo_r <= shut_en & p.sense_closed;
      opn_r <= shut_en & p.sense_open;
    end
  end

  assign mod_en_out          = mod_r;
  assign shutter_drive_out   = req_r;
  assign shutter_closed_out  = clo_r;
  assign shutter_open_out    = opn_r;
  assign shutter_fault_out   = sh_flt_r;
  assign over_temp_fault_out = ot_flt_r;
  assign shutdown_out        = sh_flt_r | ot_flt_r;

  // modulation gating by the safety loop and the latched faults
  chk_loop_gates_mod: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    !p.safety_loop |=> !mod_en_out)
    else $error("modulation with loop open");
  chk_mod_follows: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    mod_req_in && p.safety_loop && !any_fault |=> mod_en_out)
    else $error("modulation not granted");
  chk_unfit_mod: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    !fitted && p.safety_loop && mod_req_in && !any_fault |=> mod_en_out)
    else $error("open shutter loop blocked modulation");
  chk_shutdown_mod: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    shutdown_out |=> !mod_en_out)
    else $error("modulation during shutdown");

  // position status follows the fitted, fault-free shutter
  chk_closed_needs_fit: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    shutter_closed_out |-> $past(fitted) && $past(p.sense_closed))
    else $error("bad closed");
  chk_closed_no_fault: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    $past(any_fault) |-> !shutter_closed_out)
    else $error("closed during fault");
  chk_closed_follows: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    shut_en && p.sense_closed |=> shutter_closed_out)
    else $error("closed lost");
  chk_open_follows: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    $past(shut_en) && $past(p.sense_open) |-> shutter_open_out)
    else $error("open lost");
  chk_unfit_idle: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    !fitted |=> !shutter_drive_out && !shutter_open_out)
    else $error("unfitted active");

  // drive level and travel sequencing
  sequence seq_travel_start;
    (state_r == sis_pkg::SIS_MOVING) && (tmr_r == TMR_W'(TRAVEL_CYC));
  endsequence
  sequence seq_travel_late;
    (state_r == sis_pkg::SIS_MOVING) && tmr_done && !at_target && shut_en;
  endsequence
  chk_drive_level: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    shut_en |=> shutter_drive_out == $past(cmd_open))
    else $error("drive level");
  chk_timer_load: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    req_change |=> tmr_r == TMR_W'(TRAVEL_CYC))
    else $error("timer not loaded");
  chk_travel_start: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    req_change && !sh_flt_set |=> seq_travel_start)
    else $error("travel not started");
  chk_timer_count: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    !tmr_done && !req_change |=> tmr_r == $past(tmr_r) - 1'b1)
    else $error("timer not counting");
  chk_move_done: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    (state_r == sis_pkg::SIS_MOVING) && at_target && !req_change && shut_en
    |=> (state_r == sis_pkg::SIS_IDLE))
    else $error("travel not finished");
  chk_timeout_fault: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    seq_travel_late |=> shutter_fault_out)
    else $error("travel timeout missed");
  chk_fault_closes: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    shutdown_out |=> !shutter_drive_out)
    else $error("shutter driven during shutdown");
  chk_fault_state: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    any_fault |=> (state_r == sis_pkg::SIS_FAULT))
    else $error("sequencer left fault state");

  // latched faults: raised one edge after the cause, held until cleared
  chk_shfault_latch: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    sh_flt_set |=> shutter_fault_out)
    else $error("shutter fault not latched");
  chk_err_wins: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    fitted && p.shutter_err |=> shutter_fault_out)
    else $error("reported shutter fault lost");
  chk_shfault_hold: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    shutter_fault_out && !fault_clr_in |=> shutter_fault_out)
    else $error("shutter fault dropped");
  chk_ot_latch: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    p.over_temp |=> over_temp_fault_out && shutdown_out)
    else $error("over temp");
  chk_ot_hold: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    over_temp_fault_out && !fault_clr_in |=> over_temp_fault_out)
    else $error("over temp fault dropped");
endmodule
`default_nettype wire

// >>> sis_shutter_model.sv
// shutter mechanism with two end switches
// assumes drive is sampled on the core clock rising edge
`timescale 1ns/1ps
`default_nettype none
module sis_shutter_model (
  input  wire logic clk_in,
  input  wire logic drive_in,
  input  wire logic stuck_in,
  output logic      open_out,
  output logic      closed_out
);
  logic [3:0] pos_r = 4'h0;
  // one step a cycle toward the driven end, none when jammed
  always_ff @(posedge clk_in) begin
    if (!stuck_in && drive_in && pos_r != 4'h8) pos_r <= pos_r + 4'h1;
    else if (!stuck_in && !drive_in && pos_r != 4'h0) pos_r <= pos_r - 4'h1;
  end
  // end switches only at the two stops
  assign open_out   = (pos_r == 4'h8);
  assign closed_out = (pos_r == 4'h0);
endmodule
`default_nettype wire

// >>> tb_top.sv
// directed bench for the shutter interlock supervisor
// assumes the shutter model sits behind the field pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, mod_req, clr, safety, sloop, oreq, err, ot, stuck;
  wire logic s_open, s_closed, mod_en, drive, closed, opened, sfault, tfault, sdown;
  sis_pkg::sis_pins_s pins;
  int n_errors = 0;
  int n_compared = 0;
  assign pins = {safety, sloop, oreq, s_open, s_closed, err, ot};
  sis_supervisor #(.TRAVEL_CYC(20)) i_sis_supervisor (.core_clk_in(clk), .srst_in(rst),
    .pins_in(pins), .mod_req_in(mod_req), .fault_clr_in(clr), .mod_en_out(mod_en),
    .shutter_drive_out(drive), .shutter_closed_out(closed), .shutter_open_out(opened),
    .shutter_fault_out(sfault), .over_temp_fault_out(tfault), .shutdown_out(sdown));
  sis_shutter_model i_sis_shutter_model (.clk_in(clk), .drive_in(drive),
    .stuck_in(stuck), .open_out(s_open), .closed_out(s_closed));
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog, about fifteen times the sequence length
  initial begin
    #60000;
    n_errors++;
    give_verdict;
  end
  // main sequence, inputs change on falling edges
  initial begin
    {rst, mod_req, clr, safety, sloop, oreq, err, ot, stuck} = 9'h130;
    step(5);
    chk("shutdown in reset", sdown, 1'b0);
    rst = 1'b0;
    step(8);
    chk("closed status", closed, 1'b1);
    mod_req = 1'b1;
    step(8);
    chk("mod loop closed", mod_en, 1'b1);
    safety = 1'b0; // series switch opened
    step(8);
    chk("mod loop open", mod_en, 1'b0);
    safety = 1'b1;
    oreq = 1'b1;
    step(6);
    chk("drive open", drive, 1'b1);
    step(14);
    chk("open status", opened, 1'b1);
    chk("closed while open", closed, 1'b0);
    oreq = 1'b0;
    step(20);
    chk("closed again", closed, 1'b1);
    sloop = 1'b0;
    oreq = 1'b1;
    step(10);
    chk("drive unfitted", drive, 1'b0);
    chk("mod unfitted", mod_en, 1'b1);
    chk("closed unfitted", closed, 1'b0);
    oreq = 1'b0;
    sloop = 1'b1;
    step(8);
    stuck = 1'b1;
    oreq = 1'b1;
    step(16);
    chk("fault early", sfault, 1'b0);
    step(20);
    chk("travel timeout", sfault, 1'b1);
    chk("shutdown shutter", sdown, 1'b1);
    chk("mod in fault", mod_en, 1'b0);
    chk("closed in fault", closed, 1'b0);
    stuck = 1'b0;
    oreq = 1'b0;
    step(8);
    clr = 1'b1;
    step(2);
    clr = 1'b0;
    step(2);
    chk("fault cleared", sfault, 1'b0);
    err = 1'b1;
    step(8);
    chk("reported fault", sfault, 1'b1);
    err = 1'b0;
    ot = 1'b1;
    step(8);
    chk("over temp", tfault, 1'b1);
    ot = 1'b0;
    step(8);
    chk("over temp latched", sdown, 1'b1);
    clr = 1'b1;
    step(2);
    clr = 1'b0;
    step(3);
    chk("faults cleared", sdown, 1'b0);
    chk("mod resumes", mod_en, 1'b1);
    give_verdict;
  end
endmodule
`default_nettype wire
